// ===== logic/timebase_rtc_defs.vh
// Constants for the time base, RTC tick, power-down and reset controller.
// Included by the controller and its divider; holds definitions only.
`ifndef TIMEBASE_RTC_DEFS_VH
`define TIMEBASE_RTC_DEFS_VH
`define RTC_CONTROL_ADDR    8'h09
`define STATUS_FLAGS_ADDR   8'h0a
`define IRQ_CTRL_B_ADDR     8'h1e
`define RTC_CONTROL_RESET   8'h07
`define IRQ_CTRL_B_RESET    8'h00
`define RTC_DIV_LSB         0
`define RTC_DIV_MSB         2
`define RTC_FASTOSC_BIT     4
`define IRQ_TB_EN_BIT       1
`define IRQ_RT_EN_BIT       2
`define IRQ_TB_FLAG_BIT     5
`define IRQ_RT_FLAG_BIT     6
`define STAT_PDF_BIT        4
`define STAT_TO_BIT         5
`define TB_MIN_EXP          12
`define RTC_MIN_EXP         8
`define TB_VECTOR           12'h014
`define RT_VECTOR           12'h018
`define RESET_VECTOR        12'h000
`define STARTUP_CYCLES      1024
`define STARTUP_CNT_W       11
`endif

// ===== logic/mft_divider.v
// Multi-function timer divider: a free-running count on the timing clock tick
// that produces time-base and RTC time-out pulses.
// Assumes timeTick is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
`include "timebase_rtc_defs.vh"
module mft_divider (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rstSync_n,
  input  wire       clear,
  // Timing source and selections
  input  wire       timeTick,
  input  wire [1:0] tbSel,
  input  wire [2:0] rtcSel,
  // Time-out pulses
  output reg        tbTimeout,
  output reg        rtcTimeout
);
  reg  [15:0] count_q;
  wire [15:0] countNext = count_q + 16'h0001;

  // A time-out fires when the selected stage carries out.
  function carry;
    input [15:0] cur;
    input [15:0] nxt;
    input [3:0]  bitIdx;
    begin
      carry = cur[bitIdx] & ~nxt[bitIdx];
    end
  endfunction

  always @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count_q    <= 16'h0000;
      tbTimeout  <= 1'b0;
      rtcTimeout <= 1'b0;
    end else if (clear) begin
      count_q    <= 16'h0000;
      tbTimeout  <= 1'b0;
      rtcTimeout <= 1'b0;
    end else begin
      tbTimeout  <= 1'b0;
      rtcTimeout <= 1'b0;
      if (timeTick) begin
        count_q    <= countNext;
        tbTimeout  <= carry(count_q, countNext, 4'd`TB_MIN_EXP - 4'd1 + {2'b00, tbSel});
        rtcTimeout <= carry(count_q, countNext, 4'd`RTC_MIN_EXP - 4'd1 + {1'b0, rtcSel});
      end
    end
  end
endmodule

// ===== logic/timebase_rtc_halt_reset_ctrl.v
// Time base, RTC tick, power-down entry and wake-up, start-up delay and
// chip-reset control for a small microcontroller core.
// Assumes the core sends one-cycle instruction pulses on core_clk and that
// asynchronous pins are raw.
//
// Operation
// - Time base period set by option, 2^12..2^15.
// - Time-base time-out sets periodic tick flag.
// - Enabled tick flag with stack room calls 14H.
// - Three-bit field selects RTC divide 2^8..2^15.
// - RTC time-out sets clock tick flag.
// - Enabled clock flag with stack room calls 18H.
// - Power-down stops system oscillator; watchdog oscillator runs.
// - Power-down keeps RAM, registers, port states.
// - Power-down entry clears and restarts watchdog when watchdog oscillator selected.
// - Power-down sets powerdown flag, clears expired flag.
// - LCD timing keeps running in power-down when watchdog oscillator selected.
// - Wake on reset, interrupt, port edge, watchdog.
// - Powerdown flag: cleared power-up/watchdog clear, set halt.
// - Watchdog in power-down: flag, warm reset.
// - Each port A bit wake-enabled by option.
// - Port or blocked interrupt wake continues next instruction.
// - Flag already set before halt cannot wake.
// - Wake-up inserts 1024-cycle wait before resuming.
// - Power-up imposes the same 1024-cycle delay.
// - Expired/powerdown flag pair per reset cause.
// - Chip reset clears PC, interrupts, timers, ports.
// - Non-warm resets load RTC control 00 0111.
// - Tick flags stay set until serviced or cleared.
// - RTC control bit 4 selects fast oscillator start.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "timebase_rtc_defs.vh"
module timebase_rtc_halt_reset_ctrl #(
  parameter [1:0] TB_SEL      = 2'b00,
  parameter [7:0] WAKE_ENABLE = 8'hff
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  // Register port
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdata,
  // Core instruction events and state
  input  wire        haltInstr,
  input  wire        wdtClearInstr,
  input  wire        irqAck,
  input  wire        stackFull,
  input  wire        otherIrqPend,
  input  wire        timeTick,
  input  wire        wdtOverflow,
  input  wire        wdtOscSelected,
  // Pins
  input  wire        extInitPin_n,
  input  wire [7:0]  portA,
  // Control outputs
  output reg         cpuRun,
  output reg         sysOscEnable,
  output reg         holdState,
  output reg         chipReset,
  output reg         warmReset,
  output reg         wdtClear,
  output reg         irqCall,
  output reg  [11:0] irqVector,
  output reg         fastStartOsc,
  output reg         timingRunEnable
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.
  reg        rstMeta_q;
  reg        rstSync_q;
  reg        pinMeta_q;
  reg        pinSync_q;
  reg [7:0]  paMeta_q;
  reg [7:0]  paSync_q;
  reg [7:0]  paLast_q;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  always @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
      paMeta_q  <= 8'hff;
      paSync_q  <= 8'hff;
      paLast_q  <= 8'hff;
    end else begin
      pinMeta_q <= extInitPin_n;
      pinSync_q <= pinMeta_q;
      paMeta_q  <= portA;
      paSync_q  <= paMeta_q;
      paLast_q  <= paSync_q;
    end
  end

  wire pinReset = ~pinSync_q;
  wire portWake = |(paLast_q & ~paSync_q & WAKE_ENABLE);

  ////////////////////////////////////////////////////////////////////////////
  // State machine.
  localparam [3:0] ST_START = 4'b0001;
  localparam [3:0] ST_RUN   = 4'b0010;
  localparam [3:0] ST_HALT  = 4'b0100;
  localparam [3:0] ST_WAIT  = 4'b1000;

  reg [3:0]                state_q;
  reg [3:0]                state_d;
  reg [`STARTUP_CNT_W-1:0] sst_q;
  reg                      wakeIrq_q;
  reg [7:0]                rtcCtrl_q;
  reg [7:0]                irqCtrl_q;
  reg                      toFlag_q;
  reg                      pdFlag_q;
  reg                      tbArm_q;
  reg                      rtArm_q;
  reg                      pinResetLast_q;

  wire tbTimeout;
  wire rtcTimeout;
  wire inHalt    = state_q == ST_HALT;
  wire sstDone   = sst_q == `STARTUP_CYCLES - 1;
  wire tbPend    = irqCtrl_q[`IRQ_TB_FLAG_BIT] & irqCtrl_q[`IRQ_TB_EN_BIT];
  wire rtPend    = irqCtrl_q[`IRQ_RT_FLAG_BIT] & irqCtrl_q[`IRQ_RT_EN_BIT];
  // A flag that stood before halt is disarmed and cannot wake.
  wire irqWake   = (irqCtrl_q[`IRQ_TB_FLAG_BIT] & tbArm_q) |
                   (irqCtrl_q[`IRQ_RT_FLAG_BIT] & rtArm_q) | otherIrqPend;
  wire pinFall   = pinReset & ~pinResetLast_q;
  wire wdtWarm   = inHalt & wdtOverflow;
  wire wdtChip   = (state_q == ST_RUN) & wdtOverflow;
  wire anyWake   = inHalt & (irqWake | portWake | wdtOverflow);
  wire fullReset = pinFall | wdtChip;
  wire regWrRtc  = regWrite & (regAddr == `RTC_CONTROL_ADDR);
  wire regWrIrq  = regWrite & (regAddr == `IRQ_CTRL_B_ADDR);
  wire regWrStat = regWrite & (regAddr == `STATUS_FLAGS_ADDR);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_START: if (sstDone) state_d = ST_RUN;
      ST_RUN:   if (haltInstr) state_d = ST_HALT;
      ST_HALT:  if (anyWake | pinReset) state_d = ST_WAIT;
      ST_WAIT:  if (sstDone) state_d = ST_RUN;
      default:  state_d = ST_START;
    endcase
    if (pinReset && state_q != ST_HALT) state_d = ST_START;
    if (wdtChip) state_d = ST_START;
  end

  always @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q        <= ST_START;
      sst_q          <= {`STARTUP_CNT_W{1'b0}};
      wakeIrq_q      <= 1'b0;
      pinResetLast_q <= 1'b0;
    end else begin
      state_q        <= state_d;
      pinResetLast_q <= pinReset;
      if (state_d != state_q || (state_q != ST_START && state_q != ST_WAIT))
        sst_q <= {`STARTUP_CNT_W{1'b0}};
      else if (!sstDone)
        sst_q <= sst_q + {{(`STARTUP_CNT_W-1){1'b0}}, 1'b1};
      if (anyWake)
        wakeIrq_q <= irqWake & ~wdtOverflow & ~portWake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and flags.
  always @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      rtcCtrl_q <= `RTC_CONTROL_RESET;
      irqCtrl_q <= `IRQ_CTRL_B_RESET;
      toFlag_q  <= 1'b0;
      pdFlag_q  <= 1'b0;
      tbArm_q   <= 1'b1;
      rtArm_q   <= 1'b1;
    end else begin
      if (fullReset || (pinReset && inHalt)) begin
        rtcCtrl_q <= `RTC_CONTROL_RESET;
        irqCtrl_q <= `IRQ_CTRL_B_RESET;
      end else begin
        if (regWrRtc)
          rtcCtrl_q <= {3'b000, regWdata[4:0]};
        if (regWrIrq)
          irqCtrl_q <= regWdata & 8'h77;
        if (irqCall && irqVector == `TB_VECTOR)
          irqCtrl_q[`IRQ_TB_FLAG_BIT] <= 1'b0;
        if (irqCall && irqVector == `RT_VECTOR)
          irqCtrl_q[`IRQ_RT_FLAG_BIT] <= 1'b0;
        if (tbTimeout)
          irqCtrl_q[`IRQ_TB_FLAG_BIT] <= 1'b1;
        if (rtcTimeout)
          irqCtrl_q[`IRQ_RT_FLAG_BIT] <= 1'b1;
      end
      if (state_q == ST_RUN && haltInstr) begin
        tbArm_q <= ~irqCtrl_q[`IRQ_TB_FLAG_BIT];
        rtArm_q <= ~irqCtrl_q[`IRQ_RT_FLAG_BIT];
      end
      if (wdtOverflow && state_q != ST_START && state_q != ST_WAIT) begin
        toFlag_q <= 1'b1;
        if (inHalt)
          pdFlag_q <= 1'b1;
      end else if (pinReset && inHalt) begin
        toFlag_q <= 1'b0;
        pdFlag_q <= 1'b1;
      end else if (state_q == ST_RUN && haltInstr) begin
        pdFlag_q <= 1'b1;
        toFlag_q <= 1'b0;
      end else if (state_q == ST_RUN && wdtClearInstr) begin
        pdFlag_q <= 1'b0;
        toFlag_q <= 1'b0;
      end else if (regWrStat) begin
        pdFlag_q <= regWdata[`STAT_PDF_BIT];
        toFlag_q <= regWdata[`STAT_TO_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider for time base and RTC.
  mft_divider divider (
    .core_clk   (core_clk),
    .rstSync_n  (rstSync_q),
    .clear      (fullReset),
    .timeTick   (timeTick),
    .tbSel      (TB_SEL),
    .rtcSel     (rtcCtrl_q[`RTC_DIV_MSB:`RTC_DIV_LSB]),
    .tbTimeout  (tbTimeout),
    .rtcTimeout (rtcTimeout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  wire resume   = state_q == ST_WAIT && sstDone;
  wire takeIrq  = ~stackFull & (state_q == ST_RUN | (resume & wakeIrq_q));

  always @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      regRdata        <= 8'h00;
      cpuRun          <= 1'b0;
      sysOscEnable    <= 1'b1;
      holdState       <= 1'b0;
      chipReset       <= 1'b1;
      warmReset       <= 1'b0;
      wdtClear        <= 1'b1;
      irqCall         <= 1'b0;
      irqVector       <= `RESET_VECTOR;
      fastStartOsc    <= 1'b0;
      timingRunEnable <= 1'b1;
    end else begin
      regRdata <= 8'h00;
      if (regRead) begin
        case (regAddr)
          `RTC_CONTROL_ADDR:  regRdata <= rtcCtrl_q;
          `IRQ_CTRL_B_ADDR:   regRdata <= irqCtrl_q;
          `STATUS_FLAGS_ADDR: regRdata <= {2'b00, toFlag_q, pdFlag_q, 4'h0};
          default:            regRdata <= 8'h00;
        endcase
      end
      cpuRun          <= state_d == ST_RUN;
      sysOscEnable    <= state_d != ST_HALT;
      holdState       <= state_d == ST_HALT;
      timingRunEnable <= (state_d != ST_HALT) | wdtOscSelected;
      chipReset       <= fullReset | (pinReset & inHalt);
      warmReset       <= wdtWarm;
      wdtClear        <= fullReset | (state_q == ST_RUN & haltInstr & wdtOscSelected);
      fastStartOsc    <= rtcCtrl_q[`RTC_FASTOSC_BIT];
      irqCall         <= 1'b0;
      if (takeIrq && !irqCall && !irqAck) begin
        if (tbPend) begin
          irqCall   <= 1'b1;
          irqVector <= `TB_VECTOR;
        end else if (rtPend) begin
          irqCall   <= 1'b1;
          irqVector <= `RT_VECTOR;
        end
      end
    end
  end
endmodule

// ===== sim/timebase_rtc_halt_reset_ctrl_asserts.sv
// Port-level checker for the time base, power-down and reset controller.
// Assumes it is bound to the controller and sees its raw clock and reset.
`timescale 1ns/1ps
`include "timebase_rtc_defs.vh"
module timebase_rtc_halt_reset_ctrl_asserts (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Watched signals
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  input wire logic        haltInstr,
  input wire logic        wdtOverflow,
  input wire logic        stackFull,
  input wire logic        cpuRun,
  input wire logic        sysOscEnable,
  input wire logic        holdState,
  input wire logic        chipReset,
  input wire logic        warmReset,
  input wire logic        irqCall,
  input wire logic [11:0] irqVector
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Counts the cycles spent without execution, so a release is never early.
  logic [10:0] lowCnt_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) lowCnt_q <= 11'h000;
    else if (cpuRun) lowCnt_q <= 11'h000;
    else if (lowCnt_q != 11'h7ff) lowCnt_q <= lowCnt_q + 11'h001;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_wait; $rose(cpuRun) |-> lowCnt_q >= 11'd1024; endproperty
  a_wait: assert property (p_wait) else $error("execution resumed early");
  property p_halt; haltInstr && cpuRun |-> ##[1:2] holdState; endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");
  property p_osc; holdState |-> !sysOscEnable && !cpuRun; endproperty
  a_osc: assert property (p_osc) else $error("oscillator on in power-down");
  property p_ovr; holdState && wdtOverflow |-> ##[1:4] warmReset; endproperty
  a_ovr: assert property (p_ovr) else $error("no warm reset on overflow");
  property p_warm; warmReset |-> !chipReset; endproperty
  a_warm: assert property (p_warm) else $error("warm reset with chip reset");
  property p_vec; irqCall |-> irqVector == `TB_VECTOR || irqVector == `RT_VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("bad call vector");
  property p_stack; stackFull [*3] |=> !irqCall; endproperty
  a_stack: assert property (p_stack) else $error("call with full stack");
  property p_rd; !$past(regRead) |-> regRdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data outside read cycle");
  property p_rst; chipReset |-> !cpuRun && !irqCall; endproperty
  a_rst: assert property (p_rst) else $error("activity during chip reset");
endmodule
bind timebase_rtc_halt_reset_ctrl timebase_rtc_halt_reset_ctrl_asserts u_timebase_rtc_halt_reset_ctrl_asserts (
  .core_clk(core_clk), .resetn(resetn), .regRead(regRead), .regRdata(regRdata),
  .haltInstr(haltInstr), .wdtOverflow(wdtOverflow), .stackFull(stackFull), .cpuRun(cpuRun),
  .sysOscEnable(sysOscEnable), .holdState(holdState), .chipReset(chipReset),
  .warmReset(warmReset), .irqCall(irqCall), .irqVector(irqVector));

// ===== sim/tb_timebase_rtc_halt_reset_ctrl.sv
// Self-checking bench for the time base, power-down and reset controller.
// Assumes the default time-base option (2^12) and all port A wake bits enabled.
`timescale 1ns/1ps
`include "timebase_rtc_defs.vh"
module tb_timebase_rtc_halt_reset_ctrl;
  logic core_clk = 0, resetn = 0, regWrite = 0, regRead = 0, haltInstr = 0, wdtClearInstr = 0;
  logic irqAck = 0, stackFull = 1, timeTick = 0, wdtOverflow = 0, extInitPin_n = 1;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, portA = 8'hff, regRdata;
  logic cpuRun, sysOscEnable, holdState, chipReset, warmReset, wdtClear, irqCall;
  logic fastStartOsc, timingRunEnable;
  logic [11:0] irqVector;
  int failures = 0, n_tests = 0, cycles = 0, n;
  timebase_rtc_halt_reset_ctrl u_timebase_rtc_halt_reset_ctrl (
    .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .haltInstr(haltInstr),
    .wdtClearInstr(wdtClearInstr), .irqAck(irqAck), .stackFull(stackFull), .otherIrqPend(1'b0),
    .timeTick(timeTick), .wdtOverflow(wdtOverflow), .wdtOscSelected(1'b1),
    .extInitPin_n(extInitPin_n), .portA(portA), .cpuRun(cpuRun), .sysOscEnable(sysOscEnable),
    .holdState(holdState), .chipReset(chipReset), .warmReset(warmReset), .wdtClear(wdtClear),
    .irqCall(irqCall), .irqVector(irqVector), .fastStartOsc(fastStartOsc),
    .timingRunEnable(timingRunEnable));
  always #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end
  task chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Every driver step lands 1 ns after a rising edge.
  task cyc;
    @(posedge core_clk);
    #1;
  endtask
  // Each access lets one idle edge pass, so no strobe is assigned twice in one step.
  task wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1;
    cyc();
    regWrite <= 0;
    cyc();
  endtask
  task rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRead <= 1;
    cyc();
    regRead <= 0;
    chk(name, regRdata, exp);
    cyc();
  endtask
  task automatic waitHi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      cyc();
      n++;
    end
  endtask
  task ticks(input int k);
    repeat (k) begin
      timeTick <= 1;
      cyc();
      timeTick <= 0;
      cyc();
    end
  endtask
  task halt;
    haltInstr <= 1;
    cyc();
    haltInstr <= 0;
    chk("wdtclear", wdtClear, 1);
    repeat (2) cyc();
    chk("hold", {holdState, sysOscEnable, cpuRun}, 12'h4);
    chk("timing", timingRunEnable, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) cyc();
    resetn <= 1;
    waitHi(cpuRun, 1100);
    chk("startup", n >= 1024 && n <= 1040, 1);
    rd("rtc", `RTC_CONTROL_ADDR, 8'h07);
    rd("status", `STATUS_FLAGS_ADDR, 8'h00);
    rd("irq", `IRQ_CTRL_B_ADDR, 8'h00);
    rd("unmapped", 8'h40, 8'h00);
    wr(`RTC_CONTROL_ADDR, 8'hf4);
    rd("rtc", `RTC_CONTROL_ADDR, 8'h14);
    chk("fastosc", fastStartOsc, 1);
    wr(`IRQ_CTRL_B_ADDR, 8'h06);
    ticks(4095);
    rd("early", `IRQ_CTRL_B_ADDR, 8'h06);
    ticks(1);
    repeat (4) cyc();
    rd("flags", `IRQ_CTRL_B_ADDR, 8'h66);
    rd("kept", `IRQ_CTRL_B_ADDR, 8'h66);
    stackFull <= 0;
    waitHi(irqCall, 20);
    chk("tbvec", irqVector, `TB_VECTOR);
    irqAck <= 1;
    cyc();
    irqAck <= 0;
    waitHi(irqCall, 20);
    chk("rtvec", irqVector, `RT_VECTOR);
    irqAck <= 1;
    cyc();
    irqAck <= 0;
    repeat (3) cyc();
    rd("served", `IRQ_CTRL_B_ADDR, 8'h06);
    halt();
    portA <= 8'hfe;
    waitHi(cpuRun, 1100);
    chk("wake", n >= 1024 && n <= 1040, 1);
    portA <= 8'hff;
    rd("pinwake", `STATUS_FLAGS_ADDR, 8'h10);
    wdtClearInstr <= 1;
    cyc();
    wdtClearInstr <= 0;
    repeat (2) cyc();
    rd("wdtclr", `STATUS_FLAGS_ADDR, 8'h00);
    halt();
    wdtOverflow <= 1;
    cyc();
    wdtOverflow <= 0;
    waitHi(warmReset, 8);
    chk("warm", n < 8, 1);
    waitHi(cpuRun, 1100);
    rd("wdtwake", `STATUS_FLAGS_ADDR, 8'h30);
    rd("rtckept", `RTC_CONTROL_ADDR, 8'h14);
    extInitPin_n <= 0;
    // The pin passes two synchroniser stages; the chip reset pulse stands one cycle after them.
    repeat (3) cyc();
    chk("pinrst", chipReset, 1);
    extInitPin_n <= 1;
    waitHi(cpuRun, 1100);
    rd("pinstat", `STATUS_FLAGS_ADDR, 8'h30);
    rd("pinrtc", `RTC_CONTROL_ADDR, 8'h07);
    rd("pinirq", `IRQ_CTRL_B_ADDR, 8'h00);
    results();
  end
endmodule
